// ==== design/cofe_pkg.sv ====
/*
  Constants, types and status word layout of the operand and format core.
  Assumes single-clock memories that answer on the same clock as the core.
*/
package cofe_pkg;
  // ------------------------------------------------------------
  // Status word layout
  // ------------------------------------------------------------
  localparam int SW_T     = 0;
  localparam int SW_S     = 1;
  localparam int SW_IM_LO = 4;
  localparam int SW_IM_HI = 7;
  localparam int SW_Q     = 8;
  localparam int SW_M     = 9;
  localparam int SW_BL    = 28;
  localparam int SW_RB    = 29;
  localparam int SW_MD    = 30;
  localparam logic [3:0]  IM_RESET = 4'hF;
  localparam logic [31:0] PC_RESET = 32'h0000_0000;
  localparam logic [31:0] EXC_VEC  = 32'h0000_0100;
  localparam logic [31:0] INSN_LEN = 32'h0000_0002;
  localparam logic [31:0] PC_AHEAD = 32'h0000_0004;
  localparam logic [1:0]  STRAP_WAIT = 2'h2;
  // ------------------------------------------------------------
  // Operand sizes and instruction classes
  // ------------------------------------------------------------
  localparam logic [1:0] SZ_B = 2'h0;
  localparam logic [1:0] SZ_W = 2'h1;
  localparam logic [1:0] SZ_L = 2'h2;
  typedef enum logic [3:0] {
    OP_MISC = 4'h0, OP_MOVI = 4'h1, OP_ADDI = 4'h2, OP_CMPI = 4'h3,
    OP_TSTI = 4'h4, OP_LOGI = 4'h5, OP_ALU  = 4'h6, OP_MEM  = 4'h7,
    OP_LITW = 4'h8, OP_LITL = 4'h9, OP_BRA  = 4'hA, OP_BT   = 4'hB,
    OP_BF   = 4'hC, OP_BTS  = 4'hD, OP_BFS  = 4'hE, OP_BITM = 4'hF
  } cofe_op_t;
  typedef enum logic [3:0] {
    FN_MOV = 4'h0, FN_ADD = 4'h1, FN_ADDC = 4'h2, FN_ADDV = 4'h3,
    FN_SUB = 4'h4, FN_SUBC = 4'h5, FN_NEGC = 4'h6, FN_CMPEQ = 4'h7,
    FN_DT  = 4'h8, FN_AND = 4'h9, FN_OR = 4'hA, FN_XOR = 4'hB,
    FN_SHLL = 4'hC, FN_SHLR = 4'hD, FN_ROTL = 4'hE, FN_ROTR = 4'hF
  } cofe_fn_t;
  typedef enum logic [1:0] {
    ST_EXEC = 2'b00,
    ST_MEM  = 2'b01,
    ST_RMW  = 2'b11
  } cofe_state_t;
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [3:0]  be;
    logic        we;
  } cofe_dbus_t;
endpackage

// ==== design/cofe_core.sv ====
/*
  Execution core: 16-bit instructions, 32-bit registers, aligned data
  accesses with strap-selected byte order, delayed branches, flag logic.
  Assumes instruction memory answers combinationally from imem_addr and
  data memory raises dmem_ack for one cycle per request.
*/
// Overview of operation
// RULE_01 - Reset loads interrupt mask with all ones.
// RULE_02 - Flag holds compare result or carry/borrow.
// RULE_03 - User may set/clear M, Q, S, flag.
// RULE_04 - Registers always hold full 32-bit values.
// RULE_05 - Byte and word loads sign-extend to 32.
// RULE_06 - Misaligned word or longword raises address error.
// RULE_07 - Strap low big-endian, high little-endian.
// RULE_08 - Byte order latched once, never changed.
// RULE_09 - Bit 31 most significant, bit 0 least.
// RULE_10 - Fixed 16-bit instructions, mostly single cycle.
// RULE_11 - Arithmetic and logic work on 32 bits.
// RULE_12 - Immediates sign-extended arith, zero-extended logic.
// RULE_13 - Register operations; bit logic on memory.
// RULE_14 - Unconditional branch runs one slot instruction.
// RULE_15 - Conditional branches: delayed and normal forms.
// RULE_16 - Flag changes only for flag instructions.
// RULE_17 - Branch-if-set taken exactly when flag is 1; code does not take it in a delay slot.
// RULE_18 - Wide literals loaded PC-relative from memory.
// RULE_19 - Wide addresses reached via indexed indirect.
// RULE_20 - Mode bit 1 privileged; reset/exception set it.
// RULE_21 - Misalignment caught before any bus cycle.
`timescale 1ns/1ps
module cofe_core (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                rst_b,
  // Instruction fetch
  output logic [31:0]              imem_addr,
  output logic                     imem_en,
  input  wire logic [15:0]         imem_data,
  // Data memory
  output logic                     dmem_req,
  output cofe_pkg::cofe_dbus_t     dmem_out,
  input  wire logic [31:0]         dmem_rdata,
  input  wire logic                dmem_ack,
  // Strap and status
  input  wire logic                endian_strap_pin,
  output logic [31:0]              status_word,
  output logic                     little_endian,
  output logic                     running,
  output logic                     addr_err,
  output logic                     priv_fault
);
  import cofe_pkg::*;

  function automatic logic [31:0] sext8(input logic [7:0] v);
    return {{24{v[7]}}, v};
  endfunction

  function automatic logic [1:0] nb_m1(input logic [1:0] sz);
    return (sz == SZ_B) ? 2'h0 : ((sz == SZ_W) ? 2'h1 : 2'h3);
  endfunction

  function automatic logic misal(input logic [31:0] a, input logic [1:0] sz);
    return ((sz == SZ_W) && a[0]) || ((sz == SZ_L) && (a[1:0] != 2'h0));
  endfunction

  // Lowest byte lane used by the access, counted from bit 0 upward.
  function automatic logic [1:0] lane(input logic [31:0] a, input logic [1:0] sz, input logic le);
    return le ? a[1:0] : 2'(2'h3 - a[1:0] - nb_m1(sz));
  endfunction

  function automatic logic [31:0] ld_ext(input logic [31:0] d, input logic [31:0] a,
                                         input logic [1:0] sz, input logic le, input logic sx);
    logic [31:0] s;
    s = d >> {lane(a, sz, le), 3'h0};
    if (sz == SZ_B)
      return sx ? sext8(s[7:0]) : {24'h0, s[7:0]};
    else if (sz == SZ_W)
      return {{16{s[15]}}, s[15:0]};
    return s;
  endfunction

  function automatic cofe_dbus_t mk_req(input logic [31:0] a, input logic [1:0] sz, input logic le,
                                        input logic we, input logic [31:0] v);
    cofe_dbus_t r;
    logic [3:0] m;
    m = (sz == SZ_B) ? 4'h1 : ((sz == SZ_W) ? 4'h3 : 4'hF);
    r.addr  = a;
    r.we    = we;
    r.be    = 4'(m << lane(a, sz, le));
    r.wdata = v << {lane(a, sz, le), 3'h0};
    return r;
  endfunction

  // ------------------------------------------------------------
  // Byte order strap capture
  // ------------------------------------------------------------
  logic       s1_r;
  logic       s2_r;
  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;
  logic       le_r;
  logic       le_nxt;
  logic       done_r;
  logic       done_nxt;

  always_comb begin
    cnt_nxt  = cnt_r;
    le_nxt   = le_r;
    done_nxt = done_r;
    if (!done_r) begin
      if (cnt_r == STRAP_WAIT) begin
        le_nxt   = s2_r; // RULE_07
        done_nxt = 1'b1; // RULE_08
      end else begin
        cnt_nxt = 2'(cnt_r + 2'h1);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_r   <= 1'b0;
      s2_r   <= 1'b0;
      cnt_r  <= 2'h0;
      le_r   <= 1'b0;
      done_r <= 1'b0;
    end else begin
      s1_r   <= endian_strap_pin;
      s2_r   <= s1_r;
      cnt_r  <= cnt_nxt;
      le_r   <= le_nxt;
      done_r <= done_nxt;
    end
  end

  // ------------------------------------------------------------
  // Execution
  // ------------------------------------------------------------
  cofe_state_t st_r, st_nxt;
  logic [31:0] rf_r [16];
  logic [31:0] rf_nxt [16];
  logic [31:0] pc_r, pc_nxt, bt_r, bt_nxt, sw_r, sw_nxt;
  logic        bp_r, bp_nxt, dv_r, dv_nxt;
  logic        ae_r, ae_nxt, pf_r, pf_nxt;
  logic [15:0] ir_r, ir_nxt;
  cofe_dbus_t  dq_r, dq_nxt;
  logic [3:0]  op, rn, rm, fn;
  logic [7:0]  imm;
  logic [31:0] a, b, r, ea, npc, tgt, v;
  logic [32:0] w;
  logic        t, exc;

  assign op  = imem_data[15:12];
  assign rn  = imem_data[11:8];
  assign rm  = imem_data[7:4];
  assign fn  = imem_data[3:0];
  assign imm = imem_data[7:0];

  always_comb begin
    st_nxt = st_r;
    rf_nxt = rf_r;
    pc_nxt = pc_r;
    bt_nxt = bt_r;
    bp_nxt = bp_r;
    sw_nxt = sw_r;
    dv_nxt = dv_r;
    dq_nxt = dq_r;
    ir_nxt = ir_r;
    ae_nxt = 1'b0;
    pf_nxt = 1'b0;
    exc    = 1'b0;
    a      = rf_r[rn];
    b      = rf_r[rm];
    t      = sw_r[SW_T];
    r      = 32'h0;
    w      = 33'h0;
    ea     = 32'h0;
    v      = 32'h0;
    npc    = bp_r ? bt_r : 32'(pc_r + INSN_LEN);
    tgt    = 32'(pc_r + PC_AHEAD + {{23{imm[7]}}, imm, 1'b0});
    case (st_r)
      ST_EXEC: begin
        if (done_r) begin
          pc_nxt = npc; // RULE_10
          bp_nxt = 1'b0;
          case (cofe_op_t'(op))
            OP_MISC: begin
              case (fn) // RULE_03
                4'h1: sw_nxt[SW_T] = 1'b1;
                4'h2: sw_nxt[SW_T] = 1'b0;
                4'h3: sw_nxt[SW_M] = 1'b1;
                4'h4: sw_nxt[SW_M] = 1'b0;
                4'h5: sw_nxt[SW_Q] = 1'b1;
                4'h6: sw_nxt[SW_Q] = 1'b0;
                4'h7: sw_nxt[SW_S] = 1'b1;
                4'h8: sw_nxt[SW_S] = 1'b0;
                4'h9: begin
                  if (sw_r[SW_MD]) sw_nxt[SW_MD] = 1'b0;
                  else pf_nxt = 1'b1; // RULE_20
                end
                4'hA: begin
                  if (sw_r[SW_MD]) sw_nxt[SW_IM_HI:SW_IM_LO] = a[3:0];
                  else pf_nxt = 1'b1; // RULE_03
                end
                default: ;
              endcase
            end
            OP_MOVI: rf_nxt[rn] = sext8(imm); // RULE_12
            OP_ADDI: rf_nxt[rn] = 32'(a + sext8(imm)); // RULE_16
            OP_CMPI: sw_nxt[SW_T] = (rf_r[0] == sext8(imm)); // RULE_12
            OP_TSTI: sw_nxt[SW_T] = ((rf_r[0] & {24'h0, imm}) == 32'h0); // RULE_12
            OP_LOGI: begin
              case (rn[1:0])
                2'h0: rf_nxt[0] = rf_r[0] & {24'h0, imm};
                2'h1: rf_nxt[0] = rf_r[0] | {24'h0, imm};
                default: rf_nxt[0] = rf_r[0] ^ {24'h0, imm};
              endcase
            end
            OP_ALU: begin
              case (cofe_fn_t'(fn)) // RULE_02 RULE_11
                FN_MOV:  r = b;
                FN_ADD:  r = 32'(a + b);
                FN_ADDC: begin w = {1'b0, a} + {1'b0, b} + {32'h0, t}; r = w[31:0]; t = w[32]; end
                FN_ADDV: begin r = 32'(a + b); t = (a[31] == b[31]) && (r[31] != a[31]); end
                FN_SUB:  r = 32'(a - b);
                FN_SUBC: begin w = {1'b0, a} - {1'b0, b} - {32'h0, t}; r = w[31:0]; t = w[32]; end
                FN_NEGC: begin w = 33'h0 - {1'b0, b} - {32'h0, t}; r = w[31:0]; t = w[32]; end
                FN_CMPEQ: begin r = a; t = (a == b); end
                FN_DT:   begin r = 32'(a - 32'h1); t = (r == 32'h0); end
                FN_AND:  r = a & b;
                FN_OR:   r = a | b;
                FN_XOR:  r = a ^ b;
                FN_SHLL: begin r = {a[30:0], 1'b0}; t = a[31]; end
                FN_SHLR: begin r = {1'b0, a[31:1]}; t = a[0]; end
                FN_ROTL: begin r = {a[30:0], a[31]}; t = a[31]; end
                FN_ROTR: begin r = {a[0], a[31:1]}; t = a[0]; end
                default: r = a;
              endcase
              rf_nxt[rn]   = r; // RULE_04
              sw_nxt[SW_T] = t; // RULE_16
            end
            OP_MEM, OP_LITW, OP_LITL, OP_BITM: begin
              if (op == OP_MEM) begin
                ea = fn[3] ? 32'(b + rf_r[0]) : b; // RULE_19
                ir_nxt = imem_data;
              end else if (op == OP_BITM) begin
                ea = rf_r[0]; // RULE_13
                ir_nxt = imem_data;
              end else if (op == OP_LITW) begin
                ea = tgt; // RULE_18
                ir_nxt = {rn, 1'b0, 1'b0, 1'b0, 1'b0, 4'h0, 2'h0, SZ_W};
              end else begin
                ea = 32'(((pc_r + PC_AHEAD) & ~32'h3) + {22'h0, imm, 2'h0});
                ir_nxt = {rn, 1'b0, 1'b0, 1'b0, 1'b0, 4'h0, 2'h0, SZ_L};
              end
              ir_nxt[15:12] = (op == OP_BITM) ? OP_BITM : OP_MEM;
              if (op != OP_BITM && misal(ea, ir_nxt[1:0])) begin
                ae_nxt = 1'b1; // RULE_06 RULE_21
                exc    = 1'b1;
              end else begin
                dq_nxt = mk_req(ea, (op == OP_BITM) ? SZ_B : ir_nxt[1:0], le_r,
                                (op == OP_MEM) && fn[2], a);
                dv_nxt = 1'b1;
                st_nxt = ST_MEM;
              end
            end
            OP_BRA: begin
              if (!bp_r) begin
                bp_nxt = 1'b1; // RULE_14
                bt_nxt = 32'(pc_r + PC_AHEAD + {{19{imem_data[11]}}, imem_data[11:0], 1'b0});
              end
            end
            OP_BT, OP_BF: begin
              if (!bp_r && (t == (op == OP_BT))) pc_nxt = tgt; // RULE_15 RULE_17
            end
            OP_BTS, OP_BFS: begin
              if (!bp_r && (t == (op == OP_BTS))) begin
                bp_nxt = 1'b1; // RULE_15 RULE_17
                bt_nxt = tgt;
              end
            end
            default: ;
          endcase
          if (pf_nxt) exc = 1'b1;
        end
      end
      ST_MEM: begin
        if (dmem_ack) begin
          dv_nxt = 1'b0;
          st_nxt = ST_EXEC;
          if (ir_r[15:12] == OP_BITM) begin
            v = ld_ext(dmem_rdata, dq_r.addr, SZ_B, le_r, 1'b0);
            case (ir_r[11:10]) // RULE_13
              2'h0: v = v & {24'h0, ir_r[7:0]};
              2'h1: v = v | {24'h0, ir_r[7:0]};
              2'h2: v = v ^ {24'h0, ir_r[7:0]};
              default: sw_nxt[SW_T] = ((v & {24'h0, ir_r[7:0]}) == 32'h0);
            endcase
            if (ir_r[11:10] != 2'h3) begin
              dq_nxt = mk_req(dq_r.addr, SZ_B, le_r, 1'b1, v);
              dv_nxt = 1'b1;
              st_nxt = ST_RMW;
            end
          end else if (!dq_r.we) begin
            rf_nxt[ir_r[11:8]] = ld_ext(dmem_rdata, dq_r.addr, ir_r[1:0], le_r, 1'b1); // RULE_05 RULE_09
          end
        end
      end
      ST_RMW: begin
        if (dmem_ack) begin
          dv_nxt = 1'b0;
          st_nxt = ST_EXEC;
        end
      end
      default: st_nxt = ST_EXEC;
    endcase
    if (exc) begin
      pc_nxt        = EXC_VEC;
      bp_nxt        = 1'b0;
      sw_nxt[SW_MD] = 1'b1; // RULE_20
      sw_nxt[SW_BL] = 1'b1;
      sw_nxt[SW_RB] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= ST_EXEC;
      pc_r <= PC_RESET;
      bt_r <= 32'h0;
      bp_r <= 1'b0;
      dv_r <= 1'b0;
      dq_r <= '0;
      ir_r <= 16'h0;
      ae_r <= 1'b0;
      pf_r <= 1'b0;
      sw_r <= (32'h1 << SW_MD) | (32'h1 << SW_RB) | (32'h1 << SW_BL) | {24'h0, IM_RESET, 4'h0}; // RULE_01
      for (int i = 0; i < 16; i++) begin
        rf_r[i] <= 32'h0;
      end
    end else begin
      st_r <= st_nxt;
      pc_r <= pc_nxt;
      bt_r <= bt_nxt;
      bp_r <= bp_nxt;
      dv_r <= dv_nxt;
      dq_r <= dq_nxt;
      ir_r <= ir_nxt;
      ae_r <= ae_nxt;
      pf_r <= pf_nxt;
      sw_r <= sw_nxt;
      rf_r <= rf_nxt;
    end
  end

  assign imem_addr     = pc_r;
  assign imem_en       = done_r && (st_r == ST_EXEC);
  assign dmem_req      = dv_r;
  assign dmem_out      = dq_r;
  assign status_word   = sw_r;
  assign little_endian = le_r;
  assign running       = done_r;
  assign addr_err      = ae_r;
  assign priv_fault    = pf_r;
endmodule

// ==== test/cofe_core_assertions.sv ====
/*
  Port-level checker for the execution core.
  Assumes it is bound to cofe_core and sees only that module's ports.
*/
`timescale 1ns/1ps
module cofe_core_chk (
  // Clock and reset
  input wire logic                 clk,
  input wire logic                 rst_b,
  // Fetch and data sides
  input wire logic [31:0]          imem_addr,
  input wire logic                 imem_en,
  input wire logic [15:0]          imem_data,
  input wire logic                 dmem_req,
  input wire cofe_pkg::cofe_dbus_t dmem_out,
  input wire logic [31:0]          dmem_rdata,
  input wire logic                 dmem_ack,
  // Strap and status
  input wire logic                 endian_strap_pin,
  input wire logic [31:0]          status_word,
  input wire logic                 little_endian,
  input wire logic                 running,
  input wire logic                 addr_err,
  input wire logic                 priv_fault
);
  import cofe_pkg::*;
  logic [3:0] op;
  logic       slot_r;
  assign op = imem_data[15:12];
  // Marks the instruction after a delayed branch, whose pc step is not sequential when the branch is taken.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      slot_r <= 1'b0;
    end else if (imem_en) begin
      slot_r <= op inside {OP_BRA, OP_BTS, OP_BFS};
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_start;
    !running |-> status_word[SW_IM_HI:SW_IM_LO] == IM_RESET && status_word[SW_MD];
  endproperty
  a_start: assert property (p_start) else $error("status word wrong before start");
  property p_strap;
    $rose(running) |-> little_endian == endian_strap_pin;
  endproperty
  a_strap: assert property (p_strap) else $error("byte order differs from strap");
  property p_fixed;
    running && $past(running) |-> $stable(little_endian);
  endproperty
  a_fixed: assert property (p_fixed) else $error("byte order changed while running");
  property p_align;
    dmem_req |-> !(dmem_out.be == 4'hF && dmem_out.addr[1:0] != 2'h0) &&
                 !(dmem_out.be inside {4'h3, 4'hC} && dmem_out.addr[0]);
  endproperty
  a_align: assert property (p_align) else $error("misaligned access on bus");
  property p_err;
    addr_err |-> !dmem_req && status_word[SW_MD] && status_word[SW_BL] ##1 !addr_err;
  endproperty
  a_err: assert property (p_err) else $error("address error handling wrong");
  property p_priv;
    priv_fault |-> status_word[SW_MD] && !$past(status_word[SW_MD]);
  endproperty
  a_priv: assert property (p_priv) else $error("privilege fault outside user mode");
  property p_hold;
    dmem_req && !dmem_ack |=> dmem_req && $stable(dmem_out);
  endproperty
  a_hold: assert property (p_hold) else $error("data request dropped or changed");
  property p_nofetch;
    dmem_req |-> !imem_en;
  endproperty
  a_nofetch: assert property (p_nofetch) else $error("fetch during data access");
  property p_step;
    imem_en && op inside {OP_MOVI, OP_ADDI} && !slot_r |=> imem_addr == $past(imem_addr) + INSN_LEN;
  endproperty
  a_step: assert property (p_step) else $error("pc did not step by one instruction");
  property p_keep_t;
    imem_en && op inside {OP_MOVI, OP_ADDI} |=> status_word[SW_T] == $past(status_word[SW_T]);
  endproperty
  a_keep_t: assert property (p_keep_t) else $error("flag changed by plain op");
  property p_bf;
    imem_en && op == OP_BF && !slot_r && status_word[SW_T] |=> imem_addr == $past(imem_addr) + INSN_LEN;
  endproperty
  a_bf: assert property (p_bf) else $error("branch taken with flag set");
  c_err: cover property (addr_err);
  c_fault: cover property (priv_fault);
  c_write: cover property (dmem_req && dmem_ack && dmem_out.we);
endmodule
bind cofe_core cofe_core_chk cofe_core_chk_inst (.clk(clk), .rst_b(rst_b), .imem_addr(imem_addr),
  .imem_en(imem_en), .imem_data(imem_data), .dmem_req(dmem_req), .dmem_out(dmem_out),
  .dmem_rdata(dmem_rdata), .dmem_ack(dmem_ack), .endian_strap_pin(endian_strap_pin),
  .status_word(status_word), .little_endian(little_endian), .running(running),
  .addr_err(addr_err), .priv_fault(priv_fault));

// ==== test/cofe_mem.sv ====
/*
  Behavioural instruction and data memory holding the test program.
  Assumes one request at a time and an ack delay set by the testbench.
*/
`timescale 1ns/1ps
module cofe_mem (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  // Instruction side
  input  wire logic [31:0]          imem_addr,
  output logic [15:0]               imem_data,
  // Data side
  input  wire logic                 dmem_req,
  input  wire cofe_pkg::cofe_dbus_t dmem_out,
  output logic [31:0]               dmem_rdata,
  output logic                      dmem_ack,
  input  wire logic [3:0]           wait_n
);
  import cofe_pkg::*;
  localparam logic [15:0] PROG [0:27] = '{16'h1140, 16'h1280, 16'h7216, 16'hA002, 16'h1305, 16'h1307,
    16'h1307, 16'h7316, 16'h1444, 16'h7540, 16'h7516, 16'h1641, 16'h7264, 16'h10FF, 16'h30FF,
    16'h2001, 16'hB000, 16'h1307, 16'h7316, 16'h1080, 16'h2080, 16'h4080, 16'hC000, 16'h1309,
    16'h7316, 16'h1040, 16'hF410, 16'h7265};
  logic [15:0] imem [0:255];
  logic [31:0] dmem [0:63];
  logic [3:0]  cnt;
  initial begin
    for (int i = 0; i < 256; i++) imem[i] = (i < 28) ? PROG[i] : 16'h0000;
    imem[128] = 16'h0009;
    imem[129] = 16'h0001;
    imem[130] = 16'h000A;
    dmem[17]  = 32'h8500_0085;
  end
  assign imem_data = imem[imem_addr[8:1]];
  // Read data is valid only with the ack; otherwise the lines keep toggling.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dmem_ack   <= 1'b0;
      cnt        <= 4'h0;
      dmem_rdata <= 32'h0;
    end else if (dmem_req && !dmem_ack && cnt >= wait_n) begin
      dmem_ack   <= 1'b1;
      cnt        <= 4'h0;
      dmem_rdata <= dmem[dmem_out.addr[7:2]];
      for (int i = 0; i < 4; i++) begin
        if (dmem_out.we && dmem_out.be[i]) dmem[dmem_out.addr[7:2]][8*i +: 8] <= dmem_out.wdata[8*i +: 8];
      end
    end else begin
      dmem_ack   <= 1'b0;
      cnt        <= (dmem_req && !dmem_ack) ? cnt + 4'h1 : 4'h0;
      dmem_rdata <= ~dmem_rdata;
    end
  end
endmodule

// ==== test/cofe_core_test.sv ====
/*
  Self-checking testbench for the execution core.
  Assumes the memory model holds the test program and runs it in both byte orders.
*/
`timescale 1ns/1ps
module cofe_core_test;
  import cofe_pkg::*;
  localparam logic [31:0] EXP [0:5] = '{32'hFFFF_FF80, 32'h5, 32'hFFFF_FF85, 32'h0, 32'h5, 32'h9};
  logic        clk, rst_b, strap, imem_en, dmem_req, dmem_ack, little_endian, running, addr_err, priv_fault;
  logic [31:0] imem_addr, dmem_rdata, status_word, usr_sw, pf_sw;
  logic [15:0] imem_data;
  logic [3:0]  wait_n;
  logic        err_req;
  cofe_dbus_t  dmem_out;
  cofe_dbus_t  wq[$];
  int          num_errors, tests_run, n_err, n_pf;
  cofe_core cofe_core_inst (.clk(clk), .rst_b(rst_b), .imem_addr(imem_addr), .imem_en(imem_en),
    .imem_data(imem_data), .dmem_req(dmem_req), .dmem_out(dmem_out), .dmem_rdata(dmem_rdata),
    .dmem_ack(dmem_ack), .endian_strap_pin(strap), .status_word(status_word),
    .little_endian(little_endian), .running(running), .addr_err(addr_err), .priv_fault(priv_fault));
  cofe_mem cofe_mem_inst (.clk(clk), .rst_b(rst_b), .imem_addr(imem_addr), .imem_data(imem_data),
    .dmem_req(dmem_req), .dmem_out(dmem_out), .dmem_rdata(dmem_rdata), .dmem_ack(dmem_ack),
    .wait_n(wait_n));
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    if (rst_b && dmem_req && dmem_ack && dmem_out.we) wq.push_back(dmem_out);
    if (rst_b && addr_err) begin
      n_err++;
      err_req = dmem_req;
    end
    if (rst_b && imem_en && imem_addr == 32'h104) usr_sw = status_word;
    if (rst_b && priv_fault) begin
      n_pf++;
      pf_sw = status_word;
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic run_prog(input logic le);
    int         k;
    logic [1:0] lane;
    @(posedge clk);
    rst_b  <= 1'b0;
    strap  <= le;
    wait_n <= le ? 4'h3 : 4'h0;
    repeat (5) @(posedge clk);
    wq.delete();
    n_err = 0;
    n_pf  = 0;
    rst_b <= 1'b1;
    @(posedge clk);
    #1 check(status_word, 32'h7000_00F0);
    k = 0;
    while (running !== 1'b1 && k < 20) begin
      @(posedge clk);
      k++;
    end
    #1 check({31'h0, little_endian}, {31'h0, le});
    @(posedge clk);
    strap <= ~le;
    k = 0;
    while (n_pf == 0 && k < 2000) begin
      @(posedge clk);
      k++;
    end
    #1 check({31'h0, little_endian}, {31'h0, le});
    check(n_err, 32'h1);
    check({31'h0, err_req}, 32'h0);
    check({30'h0, usr_sw[SW_MD], usr_sw[SW_T]}, 32'h1);
    check({31'h0, pf_sw[SW_MD]}, 32'h1);
    check(wq.size(), 32'h7);
    lane = le ? 2'h0 : 2'h3;
    check({28'h0, wq[6].be}, 32'h1 << lane);
    check({24'h0, wq[6].wdata[8*lane +: 8]}, le ? 32'h19 : 32'h10);
    check({2'h0, wq[6].addr[31:2]}, 32'h10);
    lane = le ? 2'h1 : 2'h2;
    for (k = 0; k < 6; k++) begin
      check({2'h0, wq[k].addr[31:2]}, 32'h10);
      if (k == 3) begin
        check({28'h0, wq[k].be}, 32'h1 << lane);
        check({24'h0, wq[k].wdata[8*lane +: 8]}, 32'h80);
      end else begin
        check({28'h0, wq[k].be}, 32'hF);
        check(wq[k].wdata, EXP[k]);
      end
    end
  endtask
  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    strap = 1'b0;
    wait_n = 4'h0;
    num_errors = 0;
    tests_run = 0;
    run_prog(1'b0);
    run_prog(1'b1);
    give_verdict();
  end
  initial begin
    repeat (6000) @(posedge clk);
    num_errors++;
    give_verdict();
  end
endmodule
